// ---- led_shift_latch.sv ----
// Serial shift register and output latch of an eight channel LED sink driver
module lsli_led_shift_latch (
    // System clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset,
    // Serial link, clocked by the link's own clock
    input  wire logic       serialClk,
    input  wire logic       serialDataIn,
    output logic            serialDataOut,
    // Latch control and blanking
    input  wire logic       latch_load,
    input  wire logic       blankN,
    // Open-circuit sense per output
    input  wire logic [7:0] openSense,
    // LED sink outputs, open drain
    output logic      [7:0] led_sink_outputs,
    output logic      [7:0] ledSinkOe
);
    // Reset brought into the link domain
    logic       linkRstMeta_q;
    logic       linkRst_q;
    // Link domain state
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic       faultAck_q;
    // System domain state
    logic [7:0] shiftSync;
    logic       loadSync;
    logic       blankSync;
    logic [7:0] senseSync;
    logic       loadPrev_q;
    logic [7:0] latch_q;
    logic [7:0] latch_d;
    logic       faultReq_q;
    logic       faultVal_q;
    logic       faultValLink;
    wire        loadRise;
    wire        faultNew;
    wire        anyOpen;

    // Link-domain reset, synchronised release
    always_ff @(posedge serialClk) begin
        linkRstMeta_q <= reset;
        linkRst_q     <= linkRstMeta_q;
    end

    // Latch-load, blanking, sense and shift contents into the system clock
    lsli_sync #(.W(10)) uCtlSync (
        .clk     (clk_sys),
        .reset   (reset),
        .asyncIn ({latch_load, blankN, openSense}),
        .syncOut ({loadSync, blankSync, senseSync})
    );

    lsli_sync #(.W(8)) uShiftSync (
        .clk     (clk_sys),
        .reset   (reset),
        .asyncIn (shift_q),
        .syncOut (shiftSync)
    );

    // Edge of latch load in the system domain
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            loadPrev_q <= 1'b0;
        end else begin
            loadPrev_q <= loadSync;
        end
    end
    assign loadRise = loadSync & ~loadPrev_q;

    // Transparent while high, frozen while low
    assign latch_d = loadSync ? shiftSync : latch_q;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            latch_q <= lsli_pkg::LATCH_RESET;
        end else begin
            latch_q <= latch_d;
        end
    end

    // Open fault on any output enabled by the word being loaded
    assign anyOpen = |(shiftSync & senseSync);

    // Fault request toggle, value held steady while the toggle crosses
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            faultReq_q <= 1'b0;
            faultVal_q <= 1'b0;
        end else if (loadRise) begin
            faultReq_q <= ~faultReq_q;
            faultVal_q <= anyOpen;
        end
    end

    // Link side acknowledge of the fault toggle; toggle and value are
    // quasi-static because the link clock idles while latch load is busy
    always_ff @(posedge serialClk) begin
        if (linkRst_q) begin
            faultAck_q <= 1'b0;
        end else if (faultNew) begin
            faultAck_q <= faultReq_q;
        end
    end
    assign faultNew     = faultReq_q ^ faultAck_q;
    assign faultValLink = faultVal_q;

    // Next shift value: fault bits patched in, then shifted MSB first
    always_comb begin
        shift_d = shift_q;
        if (faultNew) begin
            shift_d[lsli_pkg::FAULT_HI] = faultValLink;
            shift_d[lsli_pkg::FAULT_LO] = faultValLink;
        end
        shift_d = {shift_d[6:0], serialDataIn};
    end

    // Shift register on the link clock, holds between edges
    always_ff @(posedge serialClk) begin
        if (linkRst_q) begin
            shift_q <= lsli_pkg::SHIFT_RESET;
        end else begin
            shift_q <= shift_d;
        end
    end

    // Serial output comes straight from the register end
    assign serialDataOut = shift_q[7];

    // Sink output enables: blanking and latch bit
    assign ledSinkOe        = blankSync ? 8'h00 : latch_q;
    assign led_sink_outputs = 8'h00;

endmodule : lsli_led_shift_latch

// ---- lsli_host_model.sv ----
module lsli_host_model (
    // Serial link
    output logic      serialClk,
    output logic      serialDataIn,
    input  wire logic serialDataOut
);
    timeunit 1ns;
    timeprecision 100ps;
    initial serialClk = 1'b0;
    initial serialDataIn = 1'b0;
    // One word, msb first, clock idle low between words
    task send(input logic [7:0] w, output logic [7:0] r);
        #1.3;
        for (int b = 7; b >= 0; b--) begin
            serialDataIn = w[b];
            #24 serialClk = 1'b1;
            #20 r[b] = serialDataOut;
            #4 serialClk = 1'b0;
        end
        serialDataIn = ~serialDataIn;
    endtask : send
endmodule : lsli_host_model

// ---- lsli_pkg.sv ----
// Summary of operation
// - Each rising serial clock edge shifts the serial input into the register.
// - Bit leaving the register end drives serial output on each rising edge.
// - Latch follows the shift register while latch_load is high.
// - Falling latch_load freezes the latch until latch_load rises again.
// - Fault status taken at rising latch_load overwrites fault_bit_hi and fault_bit_lo on the next serial clock edge.
// - Fault status shifts out during the next word with no extra command.
// - Blanking high turns all sinks off and keeps latch contents.
// - Blanking low lets each sink follow its latch bit.
// - Reset clears registers, turns sinks off and drives serial output low.
// - Shift register and latch are each eight bits wide.
// - Any enabled open output loads ones into both fault bits, else zeros.
// - Serial input bit appears at serial output eight clocks later.
package lsli_pkg;
    localparam int          WIDTH       = 8;
    localparam int          FAULT_HI    = 6;
    localparam int          FAULT_LO    = 5;
    localparam logic [7:0]  SHIFT_RESET = 8'h00;
    localparam logic [7:0]  LATCH_RESET = 8'h00;
    localparam int          SYNC_STAGES = 2;
endpackage : lsli_pkg

// ---- lsli_props.sv ----
module lsli_props (
    // Clocks and reset
    input wire logic       clk_sys, reset, serialClk,
    // Serial and control
    input wire logic       serialDataIn, serialDataOut, latch_load, blankN,
    // Sense and sinks
    input wire logic [7:0] openSense, led_sink_outputs, ledSinkOe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Sink enables against reset, blanking and latch; sink outputs held low; serial output changes only on serial clock rise
    property p_rst; disable iff (1'b0) reset |=> ledSinkOe == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("reset");
    property p_blank; blankN[*6] |-> ledSinkOe == 8'h00; endproperty
    a_blank: assert property (p_blank) else $error("blank");
    property p_bon; $rose(blankN) |-> ##[1:5] ledSinkOe == 8'h00; endproperty
    a_bon: assert property (p_bon) else $error("blank on");
    property p_hold;
        (!latch_load && !blankN)[*6] |-> $stable(ledSinkOe);
    endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_back;
        (!latch_load && !blankN)[*5] ##1 (!latch_load && blankN)[*7] ##1
        (!latch_load && !blankN)[*5] |-> ledSinkOe == $past(ledSinkOe, 12);
    endproperty
    a_back: assert property (p_back) else $error("unblank");
    property p_pass;
        (latch_load && !blankN && !serialClk)[*8] |-> $stable(ledSinkOe);
    endproperty
    a_pass: assert property (p_pass) else $error("pass");
    property p_low; led_sink_outputs == 8'h00; endproperty
    a_low: assert property (p_low) else $error("drain");
    property p_edge; $changed(serialDataOut) |-> $rose(serialClk); endproperty
    a_edge: assert property (p_edge) else $error("edge");
    // Main scenarios
    c_load: cover property ($fell(latch_load));
    c_blank: cover property ($fell(blankN));
    c_shift: cover property ($changed(serialDataOut));
endmodule : lsli_props
bind lsli_led_shift_latch lsli_props u_props (.*);

// ---- lsli_sync.sv ----
// Two-flop level synchroniser, one per bit
module lsli_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset,
    // Data
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] syncOut
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_q  <= '0;
            syncOut <= '0;
        end else begin
            meta_q  <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule : lsli_sync

// ---- tb_top.sv ----
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk_sys = 1'b0, reset = 1'b1, latch_load = 1'b0, blankN = 1'b0;
    logic [7:0] openSense = 8'h00, sr = 8'h00, lat, r, e;
    logic       serialClk, serialDataIn, serialDataOut, pend = 1'b0, flt;
    logic [7:0] led_sink_outputs, ledSinkOe;
    int         err_total = 0, checks = 0, nfr = 0, cyc = 0;
    always #2 clk_sys = ~clk_sys;
    lsli_led_shift_latch uut (.*);
    lsli_host_model host (.*);
    task check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task report_and_stop;
        if (err_total == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop
    // Model the shift register per edge, then send and compare
    task frame(input logic [7:0] w);
        for (int b = 7; b >= 0; b--) begin
            if (pend) sr[6:5] = {flt, flt};
            sr = {sr[6:0], w[b]};
            pend = 1'b0;
            e[b] = sr[7];
        end
        host.send(w, r);
        check(r, e);
        nfr++;
    endtask : frame
    // Latch pulse, then blank and unblank
    task load;
        @(posedge clk_sys) latch_load <= 1'b1;
        repeat (9) @(posedge clk_sys);
        check(ledSinkOe, sr);
        latch_load <= 1'b0;
        lat = sr;
        flt = |(sr & openSense);
        pend = 1'b1;
        repeat (6) @(posedge clk_sys);
        blankN <= 1'b1;
        repeat (7) @(posedge clk_sys);
        check(ledSinkOe, 8'h00);
        blankN <= 1'b0;
        repeat (6) @(posedge clk_sys);
        check(ledSinkOe, lat);
    endtask : load
    // Hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 8000) begin
            err_total++;
            report_and_stop();
        end
    end
    // Reset, warm-up word, random rounds
    initial begin
        void'($urandom(32'h850845a3));
        host.send(8'h00, r);
        @(posedge clk_sys) reset <= 1'b0;
        @(posedge clk_sys);
        check({7'h00, serialDataOut}, 8'h00);
        check(ledSinkOe, 8'h00);
        frame(8'h00);
        repeat (14) begin
            frame(8'($urandom));
            @(posedge clk_sys) openSense <= 8'($urandom);
            load();
        end
        report_and_stop();
    end
endmodule : tb_top
